// >>> wiper_loader_regs.svh
`ifndef WIPER_LOADER_REGS_SVH
`define WIPER_LOADER_REGS_SVH

// Serial word length in bits
`define WORD_BITS 9
// Channel-select bit position inside the word
`define CHAN_BIT 8
// Wiper code field, msb and lsb positions
`define CODE_MSB 7
`define CODE_LSB 0
// Wiper code width in bits
`define CODE_BITS 8
// Number of tap positions on each resistor ladder
`define TAP_COUNT 256
// Power-on preset, half of the tap range
`define MIDSCALE_CODE 8'h80
// Chip select level while no frame is open
`define CS_IDLE_LEVEL 1'b1
// Channel-select values
`define CHAN_FIRST 1'b0
`define CHAN_SECOND 1'b1

`endif

// >>> wiper_loader_pkg.sv
`default_nettype none
package wiper_loader_pkg;

  // Frame tracker states, Gray coded along idle -> frame -> load
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_FRAME = 2'b01,
    ST_LOAD = 2'b11
  } frame_state_t;

endpackage
`default_nettype wire

// >>> level_sync.sv
`timescale 1ns/1ps
`default_nettype none
// Two-stage synchroniser for a level from another domain
module level_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
)(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  // First stage, read only by the second stage
  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] next_meta;
  logic [WIDTH-1:0] next_sync_out;

  // Next values of both stages
  always_comb
  begin
    next_meta = async_in;
    next_sync_out = meta;
  end

  // Register both stages, reset to the idle level
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      meta <= RESET_VAL;
      sync_out <= RESET_VAL;
    end
    else
    begin
      meta <= next_meta;
      sync_out <= next_sync_out;
    end
  end

endmodule
`default_nettype wire

// >>> serial_shifter.sv
`timescale 1ns/1ps
`default_nettype none
`include "wiper_loader_regs.svh"
// Link-side input shift register, clocked by the serial clock
module serial_shifter
  import wiper_loader_pkg::*;
#(
  parameter int WIDTH = `WORD_BITS
)(
  input wire logic serial_clk,
  input wire logic chip_select_n,
  input wire logic serial_data_in,
  output logic [WIDTH-1:0] shift_word
);

  // Next content of the shift register
  logic [WIDTH-1:0] next_shift_word;

  // Shift msb first while selected; the oldest surplus bit falls off the top
  always_comb
  begin
    if (!chip_select_n)
      next_shift_word = {shift_word[WIDTH-2:0], serial_data_in}; // [RULE1] [RULE2] [RULE4]
    else
      next_shift_word = shift_word;
  end

  // No reset: the serial clock may stand still outside frames
  always_ff @(posedge serial_clk)
  begin
    shift_word <= next_shift_word;
  end

  // Newest bit lands at the bottom; checked bit by bit so the unreset
  // register's unknown start cannot trip it before it has filled
  a_shift_new_bit: assert property (@(posedge serial_clk) // [RULE2]
    !chip_select_n |=> shift_word[0] == $past(serial_data_in))
    else $error("newest serial bit not at the bottom");

  // Nine selected edges on, the oldest kept bit sits at the top (nine-bit default)
  a_shift_last_bits: assert property (@(posedge serial_clk) // [RULE4]
    !chip_select_n [*8] ##1 !chip_select_n
      |=> shift_word[WIDTH-1] == $past(serial_data_in, 9))
    else $error("shift register lost or misplaced a serial bit");

  // Deselected edges leave the word alone
  a_shift_hold_idle: assert property (@(posedge serial_clk) // [RULE2]
    chip_select_n |=> $stable(shift_word))
    else $error("shift register moved while deselected");

endmodule
`default_nettype wire

// >>> dual_wiper_serial_loader.sv
`timescale 1ns/1ps
`default_nettype none
`include "wiper_loader_regs.svh"

// Functional notes
// [RULE1] Nine-bit serial word, most significant bit first
// [RULE2] Shift data in on rising serial clock
// [RULE3] Select rising commits word to wiper register
// [RULE4] Surplus bits dropped, last nine kept
// [RULE5] Bit eight channel, bits seven-zero code
// [RULE6] Wiper registers preset to midscale
// [RULE7] Settings volatile, reset restores the preset
// [RULE8] Controller gives clean, debounced serial clock edges
// [RULE9] Code selects exactly one of 256 taps
// [RULE10] Channel bit zero first, one second
module dual_wiper_serial_loader
  import wiper_loader_pkg::*;
#(
  parameter int CODE_W = `CODE_BITS,
  parameter int TAPS = `TAP_COUNT
)(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic serial_clk,
  input wire logic chip_select_n,
  input wire logic serial_data_in,
  output logic [CODE_W-1:0] wiper_code_first,
  output logic [CODE_W-1:0] wiper_code_second,
  output logic [TAPS-1:0] tap_select_first,
  output logic [TAPS-1:0] tap_select_second,
  output logic commit_pulse,
  output logic committed_channel,
  output logic frame_busy
);

  // One-hot tap decode, shared by both channels
  function automatic logic [TAPS-1:0] tap_decode(input logic [CODE_W-1:0] code);
    logic [TAPS-1:0] taps;
    taps = '0;
    // Code zero picks the tap nearest the lower terminal
    taps[code] = 1'b1;
    return taps;
  endfunction

  // Word held in the link domain
  logic [`WORD_BITS-1:0] shift_word;
  // Chip select brought into the system clock domain
  // Only this copy steers the tracker; the raw pin feeds the shifter
  logic cs_sync;
  // Frame tracker state
  frame_state_t state;
  frame_state_t next_state;
  // Next values of the outputs
  logic [CODE_W-1:0] next_wiper_code_first;
  logic [CODE_W-1:0] next_wiper_code_second;
  logic [TAPS-1:0] next_tap_select_first;
  logic [TAPS-1:0] next_tap_select_second;
  logic next_commit_pulse;
  logic next_committed_channel;
  logic next_frame_busy;
  // Fields of the held word
  logic word_channel;
  logic [CODE_W-1:0] word_code;

  // Shift register runs on the serial clock itself
  serial_shifter #(
    .WIDTH(`WORD_BITS)
  ) u_shifter (
    .serial_clk(serial_clk),
    .chip_select_n(chip_select_n),
    .serial_data_in(serial_data_in),
    .shift_word(shift_word)
  );

  // Select is a pin: two flops before the frame tracker sees it
  level_sync #(
    .WIDTH(1),
    .RESET_VAL(`CS_IDLE_LEVEL)
  ) u_cs_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .async_in(chip_select_n),
    .sync_out(cs_sync)
  );

  // Split the word; read only in the load state
  // Bit eight picks the channel, the rest is the code, msb first
  assign word_channel = shift_word[`CHAN_BIT]; // [RULE5]
  assign word_code = shift_word[`CODE_MSB:`CODE_LSB]; // [RULE5]

  // Frame tracker: waits for select low, then for its return high.
  // The word is read three clocks after the rise at the earliest; the
  // serial clock is quiet by then, so the bus is stable as it crosses.
  always_comb
  begin
    next_state = state;
    case (state)
      ST_IDLE:
      begin
        // Frame opens when select goes low
        if (!cs_sync)
          next_state = ST_FRAME;
      end
      ST_FRAME:
      begin
        // Low-to-high of select closes the frame
        if (cs_sync)
          next_state = ST_LOAD; // [RULE3]
      end
      ST_LOAD:
      begin
        // One cycle to commit, then wait again
        // Select must stay high a few clocks before the next frame
        next_state = ST_IDLE;
      end
      default:
      begin
        // Recover from an illegal code
        next_state = ST_IDLE;
      end
    endcase
  end

  // Wiper registers and outputs
  always_comb
  begin
    next_wiper_code_first = wiper_code_first;
    next_wiper_code_second = wiper_code_second;
    next_commit_pulse = 1'b0;
    next_committed_channel = committed_channel;
    next_frame_busy = (next_state == ST_FRAME);
    if (state == ST_LOAD)
    begin
      // Commit the whole word; untouched channel keeps its code
      next_commit_pulse = 1'b1; // [RULE3]
      next_committed_channel = word_channel;
      if (word_channel == `CHAN_FIRST)
        next_wiper_code_first = word_code; // [RULE10]
      else
        next_wiper_code_second = word_code; // [RULE10]
    end
    // Taps follow the code in the same cycle; decoding the next code costs
    // two wide decoders but keeps code and taps from ever disagreeing
    next_tap_select_first = tap_decode(next_wiper_code_first); // [RULE9]
    next_tap_select_second = tap_decode(next_wiper_code_second); // [RULE9]
  end

  // Register everything; reset stands in for a power cycle
  // A setting survives only while this domain stays out of reset
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      state <= ST_IDLE;
      wiper_code_first <= `MIDSCALE_CODE; // [RULE6] [RULE7]
      wiper_code_second <= `MIDSCALE_CODE; // [RULE6] [RULE7]
      tap_select_first <= tap_decode(`MIDSCALE_CODE); // [RULE6]
      tap_select_second <= tap_decode(`MIDSCALE_CODE); // [RULE6]
      commit_pulse <= 1'b0;
      committed_channel <= `CHAN_FIRST;
      frame_busy <= 1'b0;
    end
    else
    begin
      state <= next_state;
      wiper_code_first <= next_wiper_code_first;
      wiper_code_second <= next_wiper_code_second;
      tap_select_first <= next_tap_select_first;
      tap_select_second <= next_tap_select_second;
      commit_pulse <= next_commit_pulse;
      committed_channel <= next_committed_channel;
      frame_busy <= next_frame_busy;
    end
  end

  // Steps of a frame as seen in the system domain
  // The commit-once and routing properties below are built from these named steps
  sequence s_frame_close;
    state == ST_FRAME ##1 state == ST_LOAD;
  endsequence

  sequence s_load_first;
    state == ST_LOAD && word_channel == `CHAN_FIRST;
  endsequence

  sequence s_load_second;
    state == ST_LOAD && word_channel == `CHAN_SECOND;
  endsequence

  // Reset leaves both wipers at midscale
  a_preset_mid: assert property (@(posedge clk) // [RULE6]
    sys_rst |=> wiper_code_first == `MIDSCALE_CODE && wiper_code_second == `MIDSCALE_CODE)
    else $error("wipers not at midscale after reset");

  // Taps reload with the preset too
  a_volatile_taps: assert property (@(posedge clk) // [RULE7]
    sys_rst |=> tap_select_first == tap_decode(`MIDSCALE_CODE)
      && tap_select_second == tap_decode(`MIDSCALE_CODE))
    else $error("taps not back at preset after reset");

  // Select rise leads to a commit within two clocks
  a_commit_on_rise: assert property (@(posedge clk) disable iff (sys_rst) // [RULE3]
    (state == ST_FRAME && cs_sync) |-> ##[1:2] commit_pulse)
    else $error("select rise did not commit the word");

  // Frame close ends in exactly one commit pulse
  a_commit_once: assert property (@(posedge clk) disable iff (sys_rst) // [RULE3]
    s_frame_close |=> commit_pulse ##1 !commit_pulse)
    else $error("commit pulse wrong length");

  // Channel zero writes the first wiper only
  a_route_first: assert property (@(posedge clk) disable iff (sys_rst) // [RULE10]
    s_load_first |=> wiper_code_first == $past(word_code) && $stable(wiper_code_second))
    else $error("channel zero write misrouted");

  // Channel one writes the second wiper only
  a_route_second: assert property (@(posedge clk) disable iff (sys_rst) // [RULE10]
    s_load_second |=> wiper_code_second == $past(word_code) && $stable(wiper_code_first))
    else $error("channel one write misrouted");

  // Exactly one tap, at the held code
  a_tap_one_hot: assert property (@(posedge clk) disable iff (sys_rst) // [RULE9]
    $onehot(tap_select_first) && tap_select_first[wiper_code_first]
      && $onehot(tap_select_second) && tap_select_second[wiper_code_second])
    else $error("tap decode not one-hot at the code");

  // Settings hold between commits
  a_hold_setting: assert property (@(posedge clk) disable iff (sys_rst) // [RULE7]
    state != ST_LOAD |=> $stable(wiper_code_first) && $stable(wiper_code_second))
    else $error("wiper changed without a commit");

  // Reported channel matches the word's top bit
  a_channel_report: assert property (@(posedge clk) disable iff (sys_rst) // [RULE5]
    state == ST_LOAD |=> committed_channel == $past(shift_word[`CHAN_BIT]))
    else $error("committed channel does not match bit eight");

  // Select pin rising at the end of a seen frame
  sequence s_pin_close;
    $rose(chip_select_n) && frame_busy;
  endsequence

  // Tracker resting with select high
  sequence s_idle_quiet;
    state == ST_IDLE && cs_sync;
  endsequence

  // Tracker idle with select freshly low
  sequence s_frame_open;
    state == ST_IDLE && !cs_sync;
  endsequence

  // Frame still open on the synchronised select
  sequence s_frame_wait;
    state == ST_FRAME && !cs_sync;
  endsequence

  // Pin rise to pulse: two sync flops, tracker and output register
  a_pin_to_commit: assert property (@(posedge clk) disable iff (sys_rst) // [RULE3]
    s_pin_close |-> ##[3:4] commit_pulse)
    else $error("select pin rise not followed by a commit");

  // A pulse only ever follows the load state
  a_commit_from_load: assert property (@(posedge clk) disable iff (sys_rst) // [RULE3]
    commit_pulse |-> $past(state == ST_LOAD))
    else $error("commit pulse without a load");

  // Load lasts a single cycle
  a_load_single: assert property (@(posedge clk) disable iff (sys_rst) // [RULE3]
    state == ST_LOAD |=> state == ST_IDLE)
    else $error("load state held too long");

  // No pulse and no frame while the link stays idle
  a_idle_no_commit: assert property (@(posedge clk) disable iff (sys_rst) // [RULE3]
    s_idle_quiet |=> !commit_pulse && state == ST_IDLE)
    else $error("commit or frame without select low");

  // Select low opens a frame on the next clock
  a_frame_opens: assert property (@(posedge clk) disable iff (sys_rst) // [RULE2]
    s_frame_open |=> state == ST_FRAME && frame_busy)
    else $error("frame not opened on select low");

  // Frame stays open while select stays low
  a_frame_holds: assert property (@(posedge clk) disable iff (sys_rst) // [RULE2]
    s_frame_wait |=> state == ST_FRAME && frame_busy && !commit_pulse)
    else $error("frame closed while select low");

  // Busy flag mirrors the open frame
  a_busy_matches: assert property (@(posedge clk) disable iff (sys_rst) // [RULE2]
    frame_busy == (state == ST_FRAME))
    else $error("frame busy flag out of step");

  // Reset clears the pulse, the busy flag and the channel report
  a_reset_quiet: assert property (@(posedge clk) // [RULE6]
    sys_rst |=> !commit_pulse && !frame_busy && committed_channel == `CHAN_FIRST)
    else $error("status outputs not cleared by reset");

  // Channel report changes only with a commit
  a_channel_stable: assert property (@(posedge clk) disable iff (sys_rst) // [RULE10]
    !commit_pulse |-> $stable(committed_channel))
    else $error("channel report moved without a commit");

  // Each tap vector is the decode of its own code
  a_taps_follow: assert property (@(posedge clk) disable iff (sys_rst) // [RULE9]
    tap_select_first == tap_decode(wiper_code_first)
      && tap_select_second == tap_decode(wiper_code_second))
    else $error("tap vector does not match its code");

endmodule
`default_nettype wire

// >>> serial_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
// Behavioural serial controller on the far side of the three-wire link
module serial_ctrl_model (
  output var logic serial_clk,
  output var logic chip_select_n,
  output var logic serial_data_in
);
  // Idle link: clock parked low, select high
  initial
  begin
    serial_clk = 1'b0;
    chip_select_n = 1'b1;
    serial_data_in = 1'b0;
  end

  // Edges with select high and data toggling; the device must ignore them
  task automatic stray_clocks(input int count);
    begin
      for (int i = 0; i < count; i++)
      begin
        serial_data_in = ~serial_data_in;
        #6 serial_clk = 1'b1;
        #6 serial_clk = 1'b0;
      end
    end
  endtask

  // One frame: lead junk bits first, then the nine-bit word, msb first
  // A lead of minus nine sends no edge at all, an empty frame
  task automatic send_frame(input logic [8:0] word, input int lead);
    logic bit_now;
    begin
      chip_select_n = 1'b0;
      for (int i = lead + 8; i >= 0; i--)
      begin
        // Junk is the inverse of the channel bit, so keeping it shows up
        bit_now = (i > 8) ? ~word[8] : word[i];
        serial_data_in = bit_now;
        #6 serial_clk = 1'b1; // one clean rising edge per bit
        #6 serial_clk = 1'b0;
      end
      // Hold select low long enough for the system clock to see it
      #200 chip_select_n = 1'b1;
      // Released data line must not keep showing the last bit
      serial_data_in = ~serial_data_in;
    end
  endtask
endmodule
`default_nettype wire

// >>> dual_wiper_serial_loader_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "wiper_loader_regs.svh"
module dual_wiper_serial_loader_tb;
  logic clk = 1'b0; // 20 MHz system clock
  logic sys_rst = 1'b1; // Synchronous reset, held at start
  wire logic serial_clk; // Link clock, driven by the model
  wire logic chip_select_n; // Frame select, active low
  wire logic serial_data_in; // Serial data
  logic [7:0] wiper_code_first;
  logic [7:0] wiper_code_second;
  logic [255:0] tap_select_first;
  logic [255:0] tap_select_second;
  logic commit_pulse;
  logic committed_channel;
  logic frame_busy;
  int miscompares = 0;
  int compares = 0;
  logic [7:0] exp_first = `MIDSCALE_CODE; // Model of the first wiper
  logic [7:0] exp_second = `MIDSCALE_CODE; // Model of the second wiper

  // Half period of 25 ns
  always #25 clk = ~clk;

  dual_wiper_serial_loader u_dual_wiper_serial_loader (
    .clk(clk), .sys_rst(sys_rst), .serial_clk(serial_clk),
    .chip_select_n(chip_select_n), .serial_data_in(serial_data_in),
    .wiper_code_first(wiper_code_first), .wiper_code_second(wiper_code_second),
    .tap_select_first(tap_select_first), .tap_select_second(tap_select_second),
    .commit_pulse(commit_pulse), .committed_channel(committed_channel),
    .frame_busy(frame_busy)
  );

  serial_ctrl_model u_serial_ctrl_model (
    .serial_clk(serial_clk), .chip_select_n(chip_select_n),
    .serial_data_in(serial_data_in)
  );

  // Compare a one-bit result
  task automatic cmp_bit(input string name, input logic exp, input logic got);
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error %s expected %0h seen %0h", name, exp, got);
    end
  endtask

  // Compare a wiper code, then its one-hot tap vector
  task automatic cmp_wiper(input string name, input logic [7:0] exp,
                           input logic [7:0] got, input logic [255:0] tap);
    compares += 2;
    if (got !== exp || tap !== (256'h1 << exp))
    begin
      miscompares++;
      $display("Error %s expected %0h seen %0h", name, exp, got);
    end
  endtask

  // Both wipers against the bench model
  task automatic check_wipers();
    cmp_wiper("first", exp_first, wiper_code_first, tap_select_first);
    cmp_wiper("second", exp_second, wiper_code_second, tap_select_second);
  endtask

  // Send one frame and judge the commit; pulse must last one cycle
  task automatic write_word(input logic [8:0] word, input int lead);
    int n;
    begin
      @(posedge clk) #1;
      u_serial_ctrl_model.send_frame(word, lead);
      cmp_bit("frame_busy", 1'b1, frame_busy);
      if (word[8] == `CHAN_SECOND)
        exp_second = word[7:0];
      else
        exp_first = word[7:0];
      // Bounded wait for the commit
      for (n = 0; n < 8 && commit_pulse !== 1'b1; n++)
        @(posedge clk) #1;
      cmp_bit("commit_pulse", 1'b1, commit_pulse);
      cmp_bit("committed_channel", word[8], committed_channel);
      check_wipers();
      @(posedge clk) #1;
      cmp_bit("commit_pulse_end", 1'b0, commit_pulse);
    end
  endtask

  // Preset after reset, nothing committed yet
  task automatic test_preset();
    check_wipers();
    cmp_bit("committed_channel", 1'b0, committed_channel);
    cmp_bit("commit_pulse", 1'b0, commit_pulse);
  endtask

  // Word table: extreme codes and asymmetric patterns catch bit reversal
  task automatic test_words();
    logic [8:0] words [6] = '{9'h000, 9'h1FF, 9'h0A5, 9'h15A, 9'h001, 9'h180};
    foreach (words[i])
      write_word(words[i], 0);
  endtask

  // Surplus leading bits are dropped, last nine kept
  task automatic test_surplus();
    write_word(9'h0C3, 3);
    write_word(9'h13C, 1);
  endtask

  // Edges with select high are ignored; an empty frame commits the held word again
  task automatic test_refused();
    write_word(9'h1C6, 0);
    u_serial_ctrl_model.stray_clocks(6);
    write_word(9'h1C6, -9);
  endtask

  // Mid-run reset models power loss and restores midscale
  task automatic test_power_loss();
    @(posedge clk) #1;
    sys_rst = 1'b1;
    repeat (4) @(posedge clk) #1;
    sys_rst = 1'b0;
    exp_first = `MIDSCALE_CODE;
    exp_second = `MIDSCALE_CODE;
    test_preset();
    repeat (4) @(posedge clk) #1;
    write_word(9'h17E, 0);
  endtask

  // Verdict and end of run
  task automatic wrap_up();
    $display("Comparisons %0d, miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    repeat (16) @(posedge clk) #1;
    sys_rst = 1'b0;
    test_preset();
    repeat (4) @(posedge clk) #1;
    test_words();
    test_surplus();
    test_refused();
    test_power_loss();
    wrap_up();
  end

  // Watchdog, far beyond the expected few microseconds
  initial
  begin
    #200000;
    miscompares++;
    wrap_up();
  end
endmodule
`default_nettype wire
